// ---- design/scmx_top.sv ----
// Serial clock multiplexer with external sync input and AXI4-Lite registers
// Function
// [RL1] Software keeps oscillator disabled before using external sync mode.
// [RL2] In external sync mode hunt status mirrors the sync pin; receiver still hunts.
// [RL3] Sync low after sync character; assembly starts at next rising receive clock.
// [RL4] Hunt interrupt enable makes both sync pin transitions raise status events.
// [RL5] Synchronised sync fall leaves hunt; enter-hunt command ends acceptance.
// [RL6] Mode bits 7:4 set, 3:2 clear gives SDLC; sync acts as flag.
// [RL7] Synchronous external sync forces single sync character transmit; sync starts reception.
// [RL8] Clock mode bit 7 enables oscillator amplifier between combined and sync pins.
// [RL9] With oscillator on, combined pin selections take the oscillator output.
// [RL10] With oscillator on, no sync pulse and no external sync mode.
// [RL11] With oscillator on in async mode, hunt status reads zero.
// [RL12] Clock mode bits 6:5 select the receive clock source.
// [RL13] Clock mode bits 4:3 select the transmit clock source.
// [RL14] Bidir pin drives only when unselected as source and bit 2 set.
// [RL15] Clock mode bits 1:0 choose what the bidir pin drives.
// [RL16] Oscillator chosen but disabled drives the bidir pin high.
// [RL17] Receiver samples on rising edge of the combined pin clock; the code samples on the rising edge of the selected receive clock rx_clk_o.
// [RL18] Source fields encode 00 combined, 01 bidir, 10 baud, 11 loop.
// [RL19] Bidir output encodes 00 oscillator, 01 transmit, 10 baud, 11 loop.
// [RL20] Software settles clock selections before enabling the clocked functions.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "scmx_params.svh"
module scmx_top
   import scmx_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire scmx_clk_src_t clk_src_i,
   input wire logic sync_i,
   output logic osc_amp_en_o,
   output logic rx_clk_o,
   output logic tx_clk_o,
   output logic bidir_clk_o,
   output logic bidir_clk_oe_o,
   output scmx_rx_ev_t rx_ev_o
);
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_full_q;
   logic w_full_q;
   logic wr_do;
   logic wr_ok;
   logic [7:0] clock_mode_q;
   logic [7:0] mode_setup_q;
   logic [7:0] ctrl_q;
   logic enter_hunt;
   logic sync_m_q;
   logic sync_s_q;
   logic sync_d_q;
   logic sync_fall;
   logic sync_edge;
   logic hunt_q;
   logic pend_q;
   logic rx_prev_q;
   logic xtal_en;
   logic async_mode;
   logic ext_mode;
   logic sdlc_mode;
   logic sync_status;
   logic comb_src;
   logic bd_val;
   logic ev_q;
   logic start_q;
   logic flag_q;
   scmx_clk_sel_t rx_sel;
   scmx_clk_sel_t tx_sel;
   scmx_bd_sel_t bd_sel;

   // Mode decode; oscillator steals the sync pin so external sync is barred
   assign xtal_en = clock_mode_q[`SCMX_CM_XTAL];
   assign async_mode = mode_setup_q[`SCMX_MD_STOP] != `SCMX_MD_SYNCMODE;
   assign ext_mode = !async_mode && !xtal_en &&
                     mode_setup_q[`SCMX_MD_SYNC] == `SCMX_MD_EXT; // RL10 RL1
   assign sdlc_mode = ext_mode && mode_setup_q[`SCMX_MD_HI] == `SCMX_MD_ALL1; // RL6
   assign rx_sel = scmx_clk_sel_t'(clock_mode_q[`SCMX_CM_RXSEL]); // RL18
   assign tx_sel = scmx_clk_sel_t'(clock_mode_q[`SCMX_CM_TXSEL]); // RL18
   assign bd_sel = scmx_bd_sel_t'(clock_mode_q[`SCMX_CM_BDIR_SEL]); // RL19
   assign osc_amp_en_o = xtal_en; // RL8

   // AXI write channel; address and data may arrive in either order
   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_ok = awaddr_q == `SCMX_ADDR_CLKMODE || awaddr_q == `SCMX_ADDR_MODE ||
                  awaddr_q == `SCMX_ADDR_CTRL || awaddr_q == `SCMX_ADDR_CMD;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_do) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SCMX_RESP_OK;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `SCMX_RESP_OK : `SCMX_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Registers are 8 bits wide, so only byte lane 0 stores
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clock_mode_q <= `SCMX_REG_RST;
         mode_setup_q <= `SCMX_REG_RST;
         ctrl_q <= `SCMX_REG_RST;
      end else if (wr_do && wstrb_q[0]) begin
         if (awaddr_q == `SCMX_ADDR_CLKMODE) begin
            clock_mode_q <= wdata_q[7:0];
         end
         if (awaddr_q == `SCMX_ADDR_MODE) begin
            mode_setup_q <= wdata_q[7:0];
         end
         if (awaddr_q == `SCMX_ADDR_CTRL) begin
            ctrl_q <= wdata_q[7:0];
         end
      end
   end
   assign enter_hunt = wr_do && wstrb_q[0] && awaddr_q == `SCMX_ADDR_CMD &&
                       wdata_q[`SCMX_CMD_HUNT];

   // Read channel; clock mode is write-only and reads as zero
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SCMX_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SCMX_RESP_OK;
         s_axi_rdata <= 32'h0000_0000;
         case (s_axi_araddr)
            `SCMX_ADDR_CLKMODE: s_axi_rdata <= 32'h0000_0000;
            `SCMX_ADDR_MODE: s_axi_rdata <= {24'h00_0000, mode_setup_q};
            `SCMX_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_q};
            `SCMX_ADDR_CMD: s_axi_rdata <= 32'h0000_0000;
            `SCMX_ADDR_STAT: begin
               s_axi_rdata[`SCMX_ST_SYNC] <= sync_status;
               s_axi_rdata[`SCMX_ST_HUNT] <= hunt_q;
               s_axi_rdata[`SCMX_ST_XTAL] <= xtal_en;
            end
            default: s_axi_rresp <= `SCMX_RESP_ERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Sync pin synchroniser; edges are taken only from the settled stages
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_m_q <= 1'b1;
         sync_s_q <= 1'b1;
         sync_d_q <= 1'b1;
      end else begin
         sync_m_q <= sync_i;
         sync_s_q <= sync_m_q;
         sync_d_q <= sync_s_q;
      end
   end
   assign sync_edge = !xtal_en && sync_s_q != sync_d_q; // RL10
   assign sync_fall = sync_edge && !sync_s_q; // RL5

   // Hunt status: sync pin in async or external mode, zero under oscillator in async mode
   always_comb begin
      if (xtal_en && async_mode) begin
         sync_status = 1'b0; // RL11
      end else if (async_mode || ext_mode) begin
         sync_status = sync_s_q; // RL2
      end else begin
         sync_status = hunt_q;
      end
   end

   // Clock muxes; combined pin is replaced by the oscillator when it runs
   assign comb_src = xtal_en ? clk_src_i.osc : clk_src_i.comb; // RL9
   always_comb begin
      case (bd_sel)
         SCMX_BD_OSC: bd_val = xtal_en ? clk_src_i.osc : 1'b1; // RL16
         SCMX_BD_TXCLK: bd_val = tx_clk_o;
         SCMX_BD_BAUD: bd_val = clk_src_i.baud;
         SCMX_BD_CLOCK_RECOVERY_LOOP_RX: bd_val = clk_src_i.clock_recovery_loop_rx;
         default: bd_val = 1'b1;
      endcase
   end
   // Registered to keep glitches off the pins; costs one cycle of skew, two for the transmit clock on the bidir pin
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_clk_o <= 1'b0;
         tx_clk_o <= 1'b0;
         bidir_clk_o <= 1'b0;
         rx_prev_q <= 1'b0;
      end else begin
         case (rx_sel) // RL12
            SCMX_SRC_COMB: rx_clk_o <= comb_src;
            SCMX_SRC_BIDIR: rx_clk_o <= clk_src_i.bidir;
            SCMX_SRC_BAUD: rx_clk_o <= clk_src_i.baud;
            default: rx_clk_o <= clk_src_i.clock_recovery_loop_tx;
         endcase
         case (tx_sel) // RL13
            SCMX_SRC_COMB: tx_clk_o <= comb_src;
            SCMX_SRC_BIDIR: tx_clk_o <= clk_src_i.bidir;
            SCMX_SRC_BAUD: tx_clk_o <= clk_src_i.baud;
            default: tx_clk_o <= clk_src_i.clock_recovery_loop_tx;
         endcase
         bidir_clk_o <= bd_val; // RL15
         rx_prev_q <= rx_clk_o;
      end
   end
   // Pin direction follows the selections with no delay
   assign bidir_clk_oe_o = clock_mode_q[`SCMX_CM_BDIR_OE] && rx_sel != SCMX_SRC_BIDIR &&
                           tx_sel != SCMX_SRC_BIDIR; // RL14
   // Receiver's inverted clock falls as the pin rises
   assign rx_ev_o.rx_sample = rx_clk_o && !rx_prev_q; // RL17

   // Hunt state; the enter-hunt command wins over a same-cycle exit
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hunt_q <= 1'b1;
         pend_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (sync_fall && ext_mode && hunt_q) begin
            pend_q <= 1'b1; // RL3
         end else if (enter_hunt || (pend_q && rx_ev_o.rx_sample)) begin
            pend_q <= 1'b0;
         end
         if (enter_hunt) begin
            hunt_q <= 1'b1; // RL5
         end else if (pend_q && rx_ev_o.rx_sample) begin
            hunt_q <= 1'b0; // RL3
            start_q <= 1'b1;
         end
      end
   end

   // Status events on both sync transitions, flag events in SDLC mode
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ev_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         ev_q <= sync_edge && ctrl_q[`SCMX_CTRL_HUNT_IE]; // RL4
         flag_q <= sync_edge && sdlc_mode; // RL6
      end
   end
   assign rx_ev_o.ext_status_event = ev_q;
   assign rx_ev_o.sdlc_flag = flag_q;
   assign rx_ev_o.assembly_start = start_q;
   assign rx_ev_o.tx_monosync = ext_mode && !sdlc_mode; // RL7

   // Checks
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   sequence s_fall_in_hunt;
      sync_fall && ext_mode && hunt_q && !enter_hunt;
   endsequence
   sequence s_sample_pending;
      pend_q && rx_ev_o.rx_sample && !enter_hunt;
   endsequence
   property p_osc_write;
      wr_do && wstrb_q[0] && awaddr_q == `SCMX_ADDR_CLKMODE |=>
         osc_amp_en_o == $past(wdata_q[`SCMX_CM_XTAL]);
   endproperty
   a_osc_write: assert property (p_osc_write) else $error("osc enable wrong"); // RL8
   property p_osc_rx;
      xtal_en && rx_sel == SCMX_SRC_COMB |=> rx_clk_o == $past(clk_src_i.osc);
   endproperty
   a_osc_rx: assert property (p_osc_rx) else $error("rx clock not osc"); // RL9
   property p_bd_oe;
      bidir_clk_oe_o |-> clock_mode_q[`SCMX_CM_BDIR_OE] && rx_sel != SCMX_SRC_BIDIR &&
                         tx_sel != SCMX_SRC_BIDIR;
   endproperty
   a_bd_oe: assert property (p_bd_oe) else $error("bidir pin driving"); // RL14
   property p_bd_high;
      bd_sel == SCMX_BD_OSC && !xtal_en |=> bidir_clk_o;
   endproperty
   a_bd_high: assert property (p_bd_high) else $error("bidir not high"); // RL16
   property p_async_zero;
      xtal_en && async_mode |-> !sync_status;
   endproperty
   a_async_zero: assert property (p_async_zero) else $error("hunt bit not 0"); // RL11
   property p_ext_mirror;
      ext_mode |-> sync_status == sync_s_q && !xtal_en;
   endproperty
   a_ext_mirror: assert property (p_ext_mirror) else $error("sync not mirrored"); // RL2
   property p_edge_event;
      ctrl_q[`SCMX_CTRL_HUNT_IE] && !xtal_en && $changed(sync_s_q) |=>
         rx_ev_o.ext_status_event;
   endproperty
   a_edge_event: assert property (p_edge_event) else $error("no status event"); // RL4
   property p_leave_hunt;
      s_fall_in_hunt |=> pend_q && hunt_q;
   endproperty
   a_leave_hunt: assert property (p_leave_hunt) else $error("no pending start"); // RL5
   property p_start;
      s_sample_pending |=> !hunt_q ##0 rx_ev_o.assembly_start;
   endproperty
   a_start: assert property (p_start) else $error("no assembly start"); // RL3
   property p_tx_clk;
      tx_sel == SCMX_SRC_BAUD |=> tx_clk_o == $past(clk_src_i.baud);
   endproperty
   a_tx_clk: assert property (p_tx_clk) else $error("tx clock wrong"); // RL13
endmodule

// ---- inc/scmx_params.svh ----
// Register map, field positions and reset values of the clock mux block
`ifndef SCMX_PARAMS_SVH
`define SCMX_PARAMS_SVH
`define SCMX_ADDR_CLKMODE 32'h0000_0000
`define SCMX_ADDR_MODE 32'h0000_0004
`define SCMX_ADDR_CTRL 32'h0000_0008
`define SCMX_ADDR_CMD 32'h0000_000C
`define SCMX_ADDR_STAT 32'h0000_0010
`define SCMX_CM_XTAL 7
`define SCMX_CM_RXSEL 6:5
`define SCMX_CM_TXSEL 4:3
`define SCMX_CM_BDIR_OE 2
`define SCMX_CM_BDIR_SEL 1:0
`define SCMX_MD_HI 7:4
`define SCMX_MD_SYNC 5:4
`define SCMX_MD_STOP 3:2
`define SCMX_MD_ALL1 4'hF
`define SCMX_MD_EXT 2'h3
`define SCMX_MD_SYNCMODE 2'h0
`define SCMX_CTRL_HUNT_IE 0
`define SCMX_CMD_HUNT 0
`define SCMX_ST_SYNC 0
`define SCMX_ST_HUNT 1
`define SCMX_ST_XTAL 2
`define SCMX_REG_RST 8'h00
`define SCMX_RESP_OK 2'h0
`define SCMX_RESP_ERR 2'h2
`endif

// ---- inc/scmx_pkg.sv ----
// Types shared by the clock mux block
package scmx_pkg;
   // Clock source select, encoding 00 combined pin .. 11 recovery loop
   typedef enum logic [1:0] {
      SCMX_SRC_COMB,
      SCMX_SRC_BIDIR,
      SCMX_SRC_BAUD,
      SCMX_SRC_CLOCK_RECOVERY_LOOP
   } scmx_clk_sel_t;
   // Bidirectional pin drive select
   typedef enum logic [1:0] {
      SCMX_BD_OSC,
      SCMX_BD_TXCLK,
      SCMX_BD_BAUD,
      SCMX_BD_CLOCK_RECOVERY_LOOP_RX
   } scmx_bd_sel_t;
   // Clock sources arriving at the mux
   typedef struct packed {
      logic comb;
      logic osc;
      logic bidir;
      logic baud;
      logic clock_recovery_loop_tx;
      logic clock_recovery_loop_rx;
   } scmx_clk_src_t;
   // Receiver side signals toward the channel
   typedef struct packed {
      logic rx_sample;
      logic assembly_start;
      logic sdlc_flag;
      logic tx_monosync;
      logic ext_status_event;
   } scmx_rx_ev_t;
endpackage

// ---- testbench/scmx_partner.sv ----
// Model of the clock sources and the external sync logic facing the channel
`timescale 1ns/100ps
module scmx_partner
   import scmx_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic sync_req_i,
   input wire logic bidir_clk_i,
   input wire logic bidir_oe_i,
   output scmx_clk_src_t src_o,
   output logic sync_o
);
   logic [5:0] tog_q = 6'h00;
   int cnt_q = 0;
   // Six slow square waves of unrelated periods, far below the sampling rate
   always_ff @(posedge clk_sys_i) begin
      cnt_q <= cnt_q + 1;
      for (int i = 0; i < 6; i++) begin
         if ((cnt_q % (i + 3)) == 0) begin
            tog_q[i] <= ~tog_q[i];
         end
      end
   end
   // Bidir wire level: the design's drive wins while its enable is high
   assign src_o = '{comb: tog_q[0], osc: tog_q[1],
                    bidir: bidir_oe_i ? bidir_clk_i : tog_q[2],
                    baud: tog_q[3], clock_recovery_loop_tx: tog_q[4], clock_recovery_loop_rx: tog_q[5]};
   // Sync drops only when told, i.e. after the sync character has passed
   always_ff @(posedge clk_sys_i) begin
      sync_o <= sync_req_i;
   end
endmodule

// ---- testbench/serial_clock_mux_and_ext_sync_test.sv ----
// Self-checking bench for the clock mux and external sync block
`timescale 1ns/100ps
`include "scmx_params.svh"
module serial_clock_mux_and_ext_sync_test
   import scmx_pkg::*;
;
   logic clk_sys_i = 1'b0, rstn_i = 1'b0, sync_req = 1'b1;
   logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sync_i, osc_en, rx_clk, tx_clk, bd, bd_oe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, v;
   logic [1:0] r;
   scmx_clk_src_t src, src_q, srcp_q;
   scmx_rx_ev_t ev;
   logic smp_q;
   int failures = 0, check_count = 0, ev_n = 0, asm_n = 0, flag_n = 0, e0;
   logic [8:0] rows [9] = '{9'h000, 9'h029, 9'h155, 9'h156, 9'h17F, 9'h184, 9'h104, 9'h00D,
                            9'h035};
   always #10 clk_sys_i = ~clk_sys_i;
   scmx_top i_scmx_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clk_src_i(src),
      .sync_i(sync_i), .osc_amp_en_o(osc_en), .rx_clk_o(rx_clk), .tx_clk_o(tx_clk),
      .bidir_clk_o(bd), .bidir_clk_oe_o(bd_oe), .rx_ev_o(ev));
   scmx_partner i_scmx_partner (.clk_sys_i(clk_sys_i), .sync_req_i(sync_req),
      .bidir_clk_i(bd), .bidir_oe_i(bd_oe), .src_o(src), .sync_o(sync_i));
   // Event counters and history; assembly must follow a receive sample
   always @(posedge clk_sys_i) begin
      src_q <= src;
      srcp_q <= src_q;
      smp_q <= ev.rx_sample;
      ev_n <= ev_n + (ev.ext_status_event === 1'b1);
      asm_n <= asm_n + (ev.assembly_start === 1'b1);
      flag_n <= flag_n + (ev.sdlc_flag === 1'b1);
      if (ev.assembly_start === 1'b1) check("asm_after_sample", smp_q, 1);
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task limit(input bit timed_out);
      if (timed_out) begin
         failures++;
         finish_test();
      end
   endtask
   // Offers both write halves together and drops each as it is taken
   task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      bit ta, tw, tb;
      @(posedge clk_sys_i);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      tb = 0; n = 0;
      while (!tb && n < 50) begin
         // Readies are looked at between edges, where they have settled
         @(negedge clk_sys_i);
         ta = awvalid && awready === 1'b1;
         tw = wvalid && wready === 1'b1;
         tb = bvalid === 1'b1;
         if (tb) check("bresp", bresp, er);
         @(posedge clk_sys_i); n++;
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      limit(!tb);
   endtask
   // Holds the address until the edge that takes it, data taken at the falling edge where rvalid is seen
   task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      bit ta, tr;
      @(posedge clk_sys_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      tr = 0; n = 0; d = 32'h0000_0000; rs = 2'h0;
      while (!tr && n < 50) begin
         @(negedge clk_sys_i);
         ta = arvalid && arready === 1'b1;
         tr = rvalid === 1'b1;
         d = rdata; rs = rresp;
         @(posedge clk_sys_i); n++;
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      limit(!tr);
   endtask
   // Toggles the sync pin and counts status events over a settle time
   task sync_to(input logic lvl, output int de, output int df, output int da);
      int e, f, g;
      e = ev_n; f = flag_n; g = asm_n;
      @(posedge clk_sys_i) sync_req <= lvl;
      repeat (30) @(posedge clk_sys_i);
      de = ev_n - e; df = flag_n - f; da = asm_n - g;
   endtask
   // Source picked by a two-bit clock select, oscillator standing in for the combined pin
   function logic pick(input logic [1:0] s, input logic x, input scmx_clk_src_t c);
      case (s)
         2'b00: pick = x ? c.osc : c.comb;
         2'b01: pick = c.bidir;
         2'b10: pick = c.baud;
         default: pick = c.clock_recovery_loop_tx;
      endcase
   endfunction
   initial begin
      int de, df, da;
      logic [7:0] cm;
      logic eb;
      repeat (16) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      check("oe_rst", bd_oe, 0);
      rd(`SCMX_ADDR_STAT, v, r);
      check("stat_rst", v, 32'h0000_0003);
      rd(`SCMX_ADDR_MODE, v, r);
      check("mode_rst", v, 32'h0000_0000);
      rd(`SCMX_ADDR_CLKMODE, v, r);
      check("clkmode_wo", v, 32'h0000_0000);
      rd(32'h0000_0020, v, r);
      check("rresp_unmapped", r, `SCMX_RESP_ERR);
      wr(32'h0000_0024, 32'h0000_00FF, `SCMX_RESP_ERR);
      // Clock selection table: clock mode value beside expected drive enable
      foreach (rows[i]) begin
         cm = rows[i][7:0];
         wr(`SCMX_ADDR_CLKMODE, {24'h0000_00, cm}, `SCMX_RESP_OK);
         repeat (4) @(posedge clk_sys_i);
         for (int k = 0; k < 40; k++) begin
            @(posedge clk_sys_i); #1;
            check("osc_amp", osc_en, cm[7]);
            check("oe", bd_oe, rows[i][8]);
            check("rx_clk", rx_clk, pick(cm[6:5], cm[7], src_q));
            check("tx_clk", tx_clk, pick(cm[4:3], cm[7], src_q));
            check("rx_sample", ev.rx_sample,
                  pick(cm[6:5], cm[7], src_q) & ~pick(cm[6:5], cm[7], srcp_q));
            case (cm[1:0])
               2'b00: eb = cm[7] ? src_q.osc : 1'b1;
               2'b10: eb = src_q.baud;
               2'b11: eb = src_q.clock_recovery_loop_rx;
               default: eb = pick(cm[4:3], cm[7], srcp_q); // Transmit clock, one more stage
            endcase
            if (rows[i][8]) check("bidir", bd, eb);
         end
      end
      // External sync, oscillator kept off first
      wr(`SCMX_ADDR_CLKMODE, 32'h0000_0000, `SCMX_RESP_OK);
      wr(`SCMX_ADDR_MODE, 32'h0000_0030, `SCMX_RESP_OK);
      wr(`SCMX_ADDR_CTRL, 32'h0000_0001, `SCMX_RESP_OK);
      check("monosync", ev.tx_monosync, 1);
      sync_to(1'b0, de, df, da);
      check("ev_fall", de, 1);
      check("assembly", da, 1);
      rd(`SCMX_ADDR_STAT, v, r);
      check("stat_low_out_of_hunt", v[1:0], 2'b00);
      sync_to(1'b1, de, df, da);
      check("ev_rise", de, 1);
      rd(`SCMX_ADDR_STAT, v, r);
      check("stat_mirror", v[0], 1);
      wr(`SCMX_ADDR_CMD, 32'h0000_0001, `SCMX_RESP_OK);
      rd(`SCMX_ADDR_STAT, v, r);
      check("hunt_again", v[1], 1);
      // Frame-mode external sync acts as a flag
      wr(`SCMX_ADDR_MODE, 32'h0000_00F0, `SCMX_RESP_OK);
      check("monosync_sdlc", ev.tx_monosync, 0);
      sync_to(1'b0, de, df, da);
      check("flag", df, 1);
      sync_to(1'b1, de, df, da);
      // Oscillator on: no external sync, async status forced low
      wr(`SCMX_ADDR_CLKMODE, 32'h0000_0080, `SCMX_RESP_OK);
      wr(`SCMX_ADDR_MODE, 32'h0000_0030, `SCMX_RESP_OK);
      check("monosync_osc", ev.tx_monosync, 0);
      sync_to(1'b0, de, df, da);
      check("ev_osc", de + da, 0);
      wr(`SCMX_ADDR_MODE, 32'h0000_0004, `SCMX_RESP_OK);
      sync_to(1'b1, de, df, da);
      rd(`SCMX_ADDR_STAT, v, r);
      check("stat_async_osc", v[2:0], 3'b100);
      // Reset in mid-run clears the clock mode and puts the receiver back in hunt
      @(posedge clk_sys_i) rstn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      check("osc_rst", osc_en, 0);
      check("oe_rst2", bd_oe, 0);
      rd(`SCMX_ADDR_STAT, v, r);
      check("stat_rst2", v, 32'h0000_0003);
      finish_test();
   end
endmodule
